// File: hdl/swb_alu.sv
// Eight-bit subtract-with-borrow arithmetic and flag generation.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module swb_alu
  import swb_pkg::*;
(
  // Operands
  input wire logic [7:0] f_val,
  input wire logic [7:0] w_val,
  input wire logic carry_in,
  // Result
  output swb_alu_out_t res
);
  logic [8:0] full;
  logic [4:0] low;
  logic borrow_in;

  always_comb begin
    borrow_in = ~carry_in;
    full = {1'b0, f_val} - {1'b0, w_val} - {8'h00, borrow_in};
    low = {1'b0, f_val[3:0]} - {1'b0, w_val[3:0]} - {4'h0, borrow_in};
    res.diff = full[7:0];
    res.flags.n = full[7];
    res.flags.z = (full[7:0] == 8'h00);
    res.flags.c = ~full[8];
    res.flags.dc = ~low[4];
    // Signed overflow: operands differ in sign and result sign follows the subtrahend.
    res.flags.ov = (f_val[7] ^ w_val[7]) & (f_val[7] ^ full[7]);
  end
endmodule : swb_alu

// File: hdl/swb_core.sv
// Execution unit for the subtract-w-from-file-with-borrow instruction.
// Assumes the data memory answers a read address combinationally and the
// instruction word is stable for the whole four-phase cycle.
// Assumes the working register and status flags live here, so the next
// instruction sees the result of this one without a forwarding path.
// A file write is a one-cycle strobe in the cycle after the write phase;
// the data memory must take it at that cycle's closing edge.
// The bank and index inputs need only be valid during the decode phase.
`timescale 1ns/1ps
module swb_core
  import swb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Instruction and addressing context
  input wire logic [15:0] instr,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  // Data memory read port
  output logic [11:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Data memory write port
  output swb_mem_wr_t mem_wr,
  // Architectural state
  output logic [7:0] w_reg,
  output swb_flags_t flags,
  output swb_phase_t phase,
  output logic exec_done
);
  typedef struct packed {
    swb_phase_t phase;
    logic hit;
    logic dest_f;
    logic [11:0] addr;
    logic [7:0] f_val;
    logic [7:0] diff;
    swb_flags_t flags_new;
    logic [7:0] w;
    swb_flags_t flags;
    swb_mem_wr_t wr;
    logic done;
  } swb_state_t;

  swb_state_t s_q;
  swb_state_t s_d;
  swb_alu_out_t alu_res;

  // Instruction fields, named once so the phase logic reads like the encoding.
  logic [5:0] op_field;
  logic dest_bit;
  logic bank_bit;
  logic [7:0] faddr;
  logic op_match;
  logic idx_window;
  logic access_hi;

  // How the file operand address is formed; exactly one way applies per word.
  typedef enum logic [3:0] {
    SWB_AM_BANKED = 4'h1,
    SWB_AM_INDEXED = 4'h2,
    SWB_AM_ACCESS_LO = 4'h4,
    SWB_AM_ACCESS_HI = 4'h8
  } swb_amode_t;

  swb_amode_t amode;
  logic [11:0] ea;
  logic [11:0] idx_addr;
  logic [11:0] banked_addr;
  logic [11:0] access_addr;

  // Write-phase commit decode.
  logic commit;
  logic commit_file;
  logic commit_w;

  assign op_field = instr[SWB_OP_HI:SWB_OP_LO];
  assign dest_bit = instr[SWB_D_BIT];
  assign bank_bit = instr[SWB_A_BIT];
  assign faddr = instr[7:0];
  assign op_match = (op_field == SWB_OPCODE);
  assign idx_window = ext_set_en && (faddr <= SWB_ILO_MAX);
  assign access_hi = (faddr >= SWB_ACCESS_HI_BASE);

  // The index sum is kept to the address width, so a base near the top wraps to bank 0.
  assign idx_addr = index_base + {4'h0, faddr};
  assign banked_addr = {bank_select_register, faddr};
  assign access_addr = access_hi ? {SWB_BANK_ACCESS_HI, faddr} :
    {SWB_BANK_ACCESS_LO, faddr};

  // A refused word still runs all four phases, but nothing is committed.
  assign commit = (s_q.phase == SWB_Q4) && s_q.hit;
  assign commit_file = commit && s_q.dest_f;
  assign commit_w = commit && !s_q.dest_f;

  // The arithmetic sees the captured operand and the committed working register and carry.
  swb_alu u_alu (
    .f_val(s_q.f_val),
    .w_val(s_q.w),
    .carry_in(s_q.flags.c),
    .res(alu_res)
  );

  always_comb begin
    s_d = s_q;
    s_d.wr.we = 1'b0;
    s_d.done = 1'b0;

    // A set bank bit always wins, so the indexed window only opens for the access form.
    if (bank_bit) begin
      amode = SWB_AM_BANKED;
    end else if (idx_window) begin
      amode = SWB_AM_INDEXED;
    end else if (access_hi) begin
      amode = SWB_AM_ACCESS_HI;
    end else begin
      amode = SWB_AM_ACCESS_LO;
    end

    // Only the selected form reaches the state; the others are computed and dropped.
    case (amode)
      SWB_AM_BANKED: begin
        ea = banked_addr;
      end
      SWB_AM_INDEXED: begin
        ea = idx_addr;
      end
      SWB_AM_ACCESS_LO: begin
        ea = access_addr;
      end
      SWB_AM_ACCESS_HI: begin
        ea = access_addr;
      end
      default: begin
        ea = access_addr;
      end
    endcase

    case (s_q.phase)
      // Decode: the operand address is frozen here, so later changes of the bank inputs
      // cannot move it.
      SWB_Q1: begin
        s_d.hit = op_match;
        s_d.dest_f = dest_bit;
        s_d.addr = ea;
        s_d.phase = SWB_Q2;
      end
      // Read: memory answers within the phase and its data is taken at the closing edge.
      SWB_Q2: begin
        s_d.f_val = rd_data;
        s_d.phase = SWB_Q3;
      end
      // Process: working register and carry are those left by the previous word.
      SWB_Q3: begin
        s_d.diff = alu_res.diff;
        s_d.flags_new = alu_res.flags;
        s_d.phase = SWB_Q4;
      end
      // Write: the flags change at the same edge as the working register, or as the file write strobe is raised.
      SWB_Q4: begin
        if (commit) begin
          s_d.flags = s_q.flags_new;
          s_d.done = 1'b1;
        end
        if (commit_file) begin
          s_d.wr.we = 1'b1;
          s_d.wr.addr = s_q.addr;
          s_d.wr.data = s_q.diff;
        end
        if (commit_w) begin
          s_d.w = s_q.diff;
        end
        s_d.phase = SWB_Q1;
      end
      default: begin
        s_d.phase = SWB_Q1;
      end
    endcase
  end

  // Working register and flags come up cleared, so the first word sees a borrow.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q.phase <= SWB_Q1;
      s_q.hit <= 1'b0;
      s_q.dest_f <= 1'b0;
      s_q.addr <= '0;
      s_q.f_val <= '0;
      s_q.diff <= '0;
      s_q.flags_new <= SWB_FLAGS_RESET;
      s_q.w <= SWB_W_RESET;
      s_q.flags <= SWB_FLAGS_RESET;
      s_q.wr <= '0;
      s_q.done <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // The read address is held in a flop, so the file operand is sampled a phase after decode.
  // Memory ports come straight from the state flops.
  assign rd_addr = s_q.addr;
  assign mem_wr = s_q.wr;

  // Architectural state and sequencing.
  assign w_reg = s_q.w;
  assign flags = s_q.flags;
  assign phase = s_q.phase;
  assign exec_done = s_q.done;
endmodule : swb_core

// File: pkg/swb_pkg.sv
// Package for the subtract-w-from-file-with-borrow execution block.
// Assumes a four-phase instruction cycle driven from mclk inside the block.
package swb_pkg;
  localparam logic [5:0] SWB_OPCODE = 6'h16;
  localparam int SWB_OP_HI = 15;
  localparam int SWB_OP_LO = 10;
  localparam int SWB_D_BIT = 9;
  localparam int SWB_A_BIT = 8;
  localparam logic [7:0] SWB_ILO_MAX = 8'h5f;
  localparam logic [7:0] SWB_ACCESS_HI_BASE = 8'h60;
  localparam logic [3:0] SWB_BANK_ACCESS_LO = 4'h0;
  localparam logic [3:0] SWB_BANK_ACCESS_HI = 4'hf;
  localparam logic [7:0] SWB_W_RESET = 8'h00;
  localparam logic [4:0] SWB_FLAGS_RESET = 5'h00;

  typedef enum logic [3:0] {
    SWB_Q1 = 4'h1,
    SWB_Q2 = 4'h2,
    SWB_Q3 = 4'h4,
    SWB_Q4 = 4'h8
  } swb_phase_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } swb_flags_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } swb_mem_wr_t;

  typedef struct packed {
    logic [7:0] diff;
    swb_flags_t flags;
  } swb_alu_out_t;
endpackage : swb_pkg

// File: test/swb_core_assertions.sv
// Port checker for the swb core.
// Bound to every swb_core instance below.
`timescale 1ns/1ps
module swb_chk import swb_pkg::*; (
  // Clock and reset
  input logic mclk,
  input logic rstn,
  // Instruction and addressing context
  input logic [15:0] instr,
  input logic ext_set_en,
  input logic [3:0] bank_select_register,
  input logic [11:0] index_base,
  // Data memory ports
  input logic [11:0] rd_addr,
  input logic [7:0] rd_data,
  input swb_mem_wr_t mem_wr,
  // Architectural state
  input logic [7:0] w_reg,
  input swb_flags_t flags,
  input swb_phase_t phase,
  input logic exec_done
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  wire [7:0] v = mem_wr.we ? mem_wr.data : w_reg;
  wire [7:0] f = instr[7:0];
  property p_ph; phase == SWB_Q1 |=> phase == SWB_Q2 ##1 phase == SWB_Q3; endproperty
  a_ph: assert property (p_ph) else $error("ph");
  property p_op; phase == SWB_Q4 |=> exec_done == ($past(instr[15:10]) == SWB_OPCODE); endproperty
  a_op: assert property (p_op) else $error("op");
  property p_wd; exec_done |-> mem_wr.we == $past(instr[9]); endproperty
  a_wd: assert property (p_wd) else $error("wd");
  property p_ws; mem_wr.we |-> $stable(w_reg); endproperty
  a_ws: assert property (p_ws) else $error("ws");
  property p_ba; phase == SWB_Q2 && instr[8] |-> rd_addr == {bank_select_register, f}; endproperty
  a_ba: assert property (p_ba) else $error("ba");
  property p_ix; phase == SWB_Q2 && !instr[8] && ext_set_en && f <= SWB_ILO_MAX |->
    rd_addr == index_base + {4'h0, f}; endproperty
  a_ix: assert property (p_ix) else $error("ix");
  property p_cb; exec_done |->
    flags.c == ($past(rd_data, 3) >= {1'b0, $past(w_reg)} + !$past(flags.c)); endproperty
  a_cb: assert property (p_cb) else $error("cb");
  property p_df; exec_done |-> v == $past(rd_data, 3) - $past(w_reg) - !$past(flags.c); endproperty
  a_df: assert property (p_df) else $error("df");
  property p_zn; exec_done |-> flags.z == (v == 8'h00) && flags.n == v[7]; endproperty
  a_zn: assert property (p_zn) else $error("zn");
  property p_ov; exec_done |-> flags.ov ==
    ($past(rd_data[7], 3) != $past(w_reg[7]) && v[7] != $past(rd_data[7], 3)); endproperty
  a_ov: assert property (p_ov) else $error("ov");
  c_f: cover property (exec_done && mem_wr.we);
  c_w: cover property (exec_done && !mem_wr.we);
  c_z: cover property (exec_done && flags.z);
  c_ix: cover property (phase == SWB_Q2 && !instr[8] && ext_set_en && f <= SWB_ILO_MAX);
endmodule : swb_chk
bind swb_core swb_chk u_chk (
  .mclk(mclk),
  .rstn(rstn),
  .instr(instr),
  .ext_set_en(ext_set_en),
  .bank_select_register(bank_select_register),
  .index_base(index_base),
  .rd_addr(rd_addr),
  .rd_data(rd_data),
  .mem_wr(mem_wr),
  .w_reg(w_reg),
  .flags(flags),
  .phase(phase),
  .exec_done(exec_done)
);

// File: test/tb.sv
// Bench for the swb core; it also plays data memory.
// Assumes the checker is bound to the core.
`timescale 1ns/1ps
module tb import swb_pkg::*;;
  logic mclk = 1'b0, rstn = 1'b0, ext_set_en = 1'b0, c = 1'b0, b8, n4, exec_done;
  logic [15:0] instr = 16'h0000;
  logic [3:0] bank_select_register = 4'h0;
  logic [11:0] index_base = 12'h000, ea, rd_addr;
  logic [7:0] rd_data = 8'h00, w = 8'h00, r, w_reg;
  logic [31:0] x, y;
  logic [33:0] ex, q[$];
  swb_mem_wr_t mem_wr;
  swb_flags_t flags;
  swb_phase_t phase;
  int seed = 79960, bad_count = 0, comparisons = 0;
  always #12.5 mclk = ~mclk;
  swb_core dut (
    .mclk(mclk),
    .rstn(rstn),
    .instr(instr),
    .ext_set_en(ext_set_en),
    .bank_select_register(bank_select_register),
    .index_base(index_base),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .mem_wr(mem_wr),
    .w_reg(w_reg),
    .flags(flags),
    .phase(phase),
    .exec_done(exec_done)
  );
  task chk(input logic [33:0] s, e, input string nm);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task final_report;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge mclk) if (exec_done === 1'b1) begin
    ex = q.size() ? q.pop_front() : 'x;
    chk({{21{mem_wr.we}} & mem_wr, w_reg, flags}, ex, "res");
  end
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (80) begin
      x = $random(seed);
      y = $random(seed);
      instr <= {x[3:0] ? SWB_OPCODE : ~SWB_OPCODE, x[13:4]};
      ext_set_en <= x[14];
      bank_select_register <= x[18:15];
      index_base <= y[19:8];
      rd_data <= y[7:0];
      ea = x[12] ? {x[18:15], x[11:4]} : x[14] && x[11:4] <= SWB_ILO_MAX ?
        y[19:8] + x[11:4] : {{4{x[11:4] >= SWB_ACCESS_HI_BASE}}, x[11:4]};
      {b8, r} = {1'b0, y[7:0]} - w - !c;
      n4 = ({1'b0, y[3:0]} - w[3:0] - !c) >> 4;
      // A refused opcode must leave the model untouched, so only matches update it.
      if (x[3:0]) begin
        q.push_back({x[13], x[13] ? {ea, r} : 20'h0, x[13] ? w : r, r[7],
          y[7] != w[7] && r[7] != y[7], r == 8'h00, !n4, !b8});
        w = x[13] ? w : r;
        c = !b8;
      end
      @(posedge mclk);
      #1 if (x[3:0]) chk(34'(rd_addr), 34'(ea), "addr");
      repeat (3) @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
    chk(34'(q.size()), 34'h0, "left");
    final_report();
  end
  // Eighty four-cycle instructions need about 8.1 us.
  initial begin
    #9000;
    bad_count++;
    final_report();
  end
endmodule : tb
